// ===== hdl/ccsf_crb_ctrl.sv
`timescale 1ns/1ps
module ccsf_crb_ctrl #(
   parameter logic [31:0] LONG_CYCLES = 32'(ccsf_pkg::LONG_CYCLES_DEF),
   parameter logic [31:0] SHORT_CYCLES = 32'(ccsf_pkg::SHORT_CYCLES_DEF)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic idle_skip_capability,
   input wire logic locality_change,
   input wire logic cmd_byte_written,
   input wire logic engine_done,
   input wire logic engine_aborted,
   output logic engine_begin,
   output logic engine_abort,
   output logic buffer_discard,
   output logic timeout_error
);
   ccsf_pkg::ccsf_state_t state_reg, state_next;
   logic [31:0] abort_reg, abort_next;
   logic [31:0] launch_reg, launch_next;
   logic [1:0] request_reg, request_next;
   logic idle_ind_reg, idle_ind_next;
   logic abort_smp_reg, abort_smp_next;
   logic abort_out_reg, abort_out_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic begin_reg, begin_next;
   logic discard_reg, discard_next;
   logic [31:0] long_cnt_reg, long_cnt_next;
   logic [31:0] short_cnt_reg, short_cnt_next;
   logic tmo_reg, tmo_next;
   logic wr_en;
   logic rd_en;
   logic wr_one;
   logic wr_zero;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      hit = (a[11:2] == b[11:2]);
   endfunction

   // execution is the one state that locks out requests and takes aborts
   function automatic logic in_exec(input ccsf_pkg::ccsf_state_t s);
      in_exec = (s == ccsf_pkg::CCSF_EXECUTION);
   endfunction

   // access phase taken in one cycle: pready high in the second cycle
   assign wr_en = psel && penable && pwrite && !pready_reg;
   assign rd_en = psel && penable && !pwrite && !pready_reg;
   assign wr_one = (pwdata == ccsf_pkg::REG_ONE);
   assign wr_zero = (pwdata == ccsf_pkg::REG_ZERO);

   always_comb begin
      state_next = state_reg;
      launch_next = launch_reg;
      request_next = request_reg;
      idle_ind_next = idle_ind_reg;
      begin_next = 1'b0;
      discard_next = 1'b0;
      if (wr_en && hit(paddr, ccsf_pkg::ADDR_REQUEST) &&
          !in_exec(state_reg)) begin // [R19]
         if (pwdata[ccsf_pkg::REQ_READY_BIT]) begin
            request_next[ccsf_pkg::REQ_READY_BIT] = 1'b1;
         end
         if (pwdata[ccsf_pkg::REQ_IDLE_BIT]) begin
            request_next[ccsf_pkg::REQ_IDLE_BIT] = 1'b1;
         end
      end
      unique case (state_reg)
         ccsf_pkg::CCSF_IDLE: begin
            request_next[ccsf_pkg::REQ_IDLE_BIT] = 1'b0;
            if (request_reg[ccsf_pkg::REQ_READY_BIT]) begin
               state_next = ccsf_pkg::CCSF_READY; // [R15] [R18]
               request_next[ccsf_pkg::REQ_READY_BIT] = 1'b0; // [R18]
               idle_ind_next = 1'b0; // [R15]
            end
         end
         ccsf_pkg::CCSF_READY: begin
            request_next[ccsf_pkg::REQ_READY_BIT] = 1'b0;
            if (cmd_byte_written) begin
               state_next = ccsf_pkg::CCSF_RECEPTION; // [R11]
            end
         end
         ccsf_pkg::CCSF_RECEPTION: begin
            request_next[ccsf_pkg::REQ_READY_BIT] = 1'b0;
            // launch only from reception, and only on a write of one
            if (wr_en && hit(paddr, ccsf_pkg::ADDR_LAUNCH) &&
                wr_one) begin // [R8] [R9]
               launch_next = ccsf_pkg::REG_ONE; // [R7]
               state_next = ccsf_pkg::CCSF_EXECUTION; // [R7] [R11]
               begin_next = 1'b1; // [R7]
            end
         end
         ccsf_pkg::CCSF_EXECUTION: begin
            // done or aborted response, then completion
            if (engine_done || engine_aborted) begin // [R3]
               launch_next = ccsf_pkg::REG_ZERO; // [R5] [R10]
               state_next = ccsf_pkg::CCSF_COMPLETION; // [R3] [R10]
            end
         end
         ccsf_pkg::CCSF_COMPLETION: begin
            // response held: no discard until a request or a locality change arrives
            if (request_reg[ccsf_pkg::REQ_READY_BIT]) begin // [R20]
               request_next[ccsf_pkg::REQ_READY_BIT] = 1'b0; // [R16]
               if (idle_skip_capability) begin
                  state_next = ccsf_pkg::CCSF_READY; // [R16]
                  discard_next = 1'b1;
               end
            end
         end
         default: begin
            state_next = ccsf_pkg::CCSF_IDLE;
         end
      endcase
      // return-to-idle beats make-ready from any state but execution and idle
      if ((request_reg[ccsf_pkg::REQ_IDLE_BIT] &&
           state_reg != ccsf_pkg::CCSF_EXECUTION &&
           state_reg != ccsf_pkg::CCSF_IDLE) || locality_change) begin
         state_next = ccsf_pkg::CCSF_IDLE; // [R12] [R13] [R17]
         idle_ind_next = 1'b1; // [R13] [R17]
         discard_next = 1'b1; // [R17]
         request_next = 2'b00;
         launch_next = ccsf_pkg::REG_ZERO;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ccsf_pkg::CCSF_IDLE; // [R14]
         idle_ind_reg <= 1'b1; // [R14]
         launch_reg <= ccsf_pkg::REG_ZERO;
         request_reg <= 2'b00;
         begin_reg <= 1'b0;
         discard_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         idle_ind_reg <= idle_ind_next;
         launch_reg <= launch_next;
         request_reg <= request_next;
         begin_reg <= begin_next;
         discard_reg <= discard_next;
      end
   end

   // abort register: software may write zero at any moment, other values only in execution
   always_comb begin
      abort_next = abort_reg;
      // sampled once more before the engine is told
      abort_smp_next = (abort_reg == ccsf_pkg::REG_ONE); // [R21]
      // registered output drops as soon as execution ends
      abort_out_next = abort_smp_next && in_exec(state_next); // [R2]
      if (wr_en && hit(paddr, ccsf_pkg::ADDR_ABORT)) begin
         // zero always accepted so a stale abort can be withdrawn
         if (in_exec(state_reg) || wr_zero) begin // [R6]
            abort_next = pwdata; // [R1]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_reg <= ccsf_pkg::REG_ZERO;
         abort_smp_reg <= 1'b0;
         abort_out_reg <= 1'b0;
      end else begin
         abort_reg <= abort_next;
         abort_smp_reg <= abort_smp_next;
         abort_out_reg <= abort_out_next;
      end
   end

   // timeout monitor
   always_comb begin
      long_cnt_next = 32'h00000000;
      short_cnt_next = 32'h00000000;
      tmo_next = tmo_reg;
      if (state_reg == ccsf_pkg::CCSF_EXECUTION && abort_smp_reg) begin
         long_cnt_next = long_cnt_reg + 32'h00000001; // [R4] [R22]
      end
      if (request_reg != 2'b00) begin
         short_cnt_next = short_cnt_reg + 32'h00000001; // [R22]
      end
      if (long_cnt_reg >= LONG_CYCLES || short_cnt_reg >= SHORT_CYCLES) begin
         tmo_next = 1'b1; // [R4] [R22]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         long_cnt_reg <= 32'h00000000;
         short_cnt_reg <= 32'h00000000;
         tmo_reg <= 1'b0;
      end else begin
         long_cnt_reg <= long_cnt_next;
         short_cnt_reg <= short_cnt_next;
         tmo_reg <= tmo_next;
      end
   end

   always_comb begin
      prdata_next = ccsf_pkg::REG_ZERO;
      pready_next = psel && penable && !pready_reg;
      pslverr_next = 1'b0;
      if (rd_en || wr_en) begin
         if (hit(paddr, ccsf_pkg::ADDR_ABORT)) begin
            prdata_next = rd_en ? abort_reg : ccsf_pkg::REG_ZERO; // [R1]
         end else if (hit(paddr, ccsf_pkg::ADDR_LAUNCH)) begin
            prdata_next = rd_en ? launch_reg : ccsf_pkg::REG_ZERO; // [R9]
         end else if (hit(paddr, ccsf_pkg::ADDR_REQUEST)) begin
            prdata_next = rd_en ? {30'h0, request_reg} : ccsf_pkg::REG_ZERO;
         end else if (hit(paddr, ccsf_pkg::ADDR_STATE)) begin
            if (rd_en) begin
               prdata_next[ccsf_pkg::STS_IDLE_BIT] = idle_ind_reg; // [R15]
               prdata_next[ccsf_pkg::STS_ERR_BIT] = tmo_reg;
            end
         end else if (hit(paddr, ccsf_pkg::ADDR_FSM)) begin
            prdata_next = rd_en ? {29'h0, state_reg} : ccsf_pkg::REG_ZERO;
         end else begin
            pslverr_next = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= ccsf_pkg::REG_ZERO;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign engine_begin = begin_reg;
   // engine may use this to stop early, or ignore it
   assign engine_abort = abort_out_reg; // [R2]
   assign buffer_discard = discard_reg;
   assign timeout_error = tmo_reg;
endmodule // ccsf_crb_ctrl

// ===== hdl/ccsf_pkg.sv
// Functional notes
// [R1] abort register: 32-bit RW, resets zero, reads back; one requests, zero withdraws
// [R2] in execution with abort set, the engine may stop early
// [R3] after abort, finish with response or aborted code, then go to completion
// [R4] after abort, finish or abandon before the long timeout
// [R5] on finish or abandon after abort, launch register is cleared
// [R6] abort writes outside execution take no effect; the code still accepts writes of zero there
// [R7] launch register: 32-bit RW, zero reset; one starts execution from reception
// [R8] launch write of one outside reception has no effect
// [R9] software writes of zero to launch are ignored
// [R10] on processing done, clear launch and enter completion
// [R11] ready to reception on first buffer byte; stay until launch
// [R12] stay in completion until return-to-idle request
// [R13] idle with idle indicator on return-to-idle or locality change
// [R14] after platform init the block starts idle with indicator set
// [R15] make-ready in idle enters ready and clears state register; the code clears only the idle indicator, the timeout error bit stays set
// [R16] idle-skip capability: make-ready in completion goes straight to ready
// [R17] return-to-idle discards buffer, goes idle, sets idle indicator
// [R18] make-ready in idle goes ready, request bit self-clears quickly
// [R19] request register writes ignored during execution
// [R20] response is held until return-to-idle or make-ready request
// [R21] abort request is registered before the execution logic uses it
// [R22] long and short timeouts are cycle-count parameters with a monitor
package ccsf_pkg;
   localparam logic [11:0] ADDR_ABORT = 12'h000;
   localparam logic [11:0] ADDR_LAUNCH = 12'h004;
   localparam logic [11:0] ADDR_REQUEST = 12'h008;
   localparam logic [11:0] ADDR_STATE = 12'h00C;
   localparam logic [11:0] ADDR_FSM = 12'h010;
   localparam logic [31:0] REG_ZERO = 32'h00000000;
   localparam logic [31:0] REG_ONE = 32'h00000001;
   localparam int REQ_READY_BIT = 0;
   localparam int REQ_IDLE_BIT = 1;
   localparam int STS_ERR_BIT = 0;
   localparam int STS_IDLE_BIT = 1;
   localparam int CMD_BYTE_BITS = 8;
   // long timeout 2 s, short timeout 200 ms, clock 5 ns
   localparam longint LONG_TIMEOUT_NS = 64'h0000000077359400;
   localparam longint SHORT_TIMEOUT_NS = 64'h000000000BEBC200;
   localparam longint CLK_PERIOD_NS = 64'h0000000000000005;
   localparam longint LONG_CYCLES_DEF = LONG_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam longint SHORT_CYCLES_DEF = SHORT_TIMEOUT_NS / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      CCSF_IDLE = 3'b000,
      CCSF_READY = 3'b001,
      CCSF_RECEPTION = 3'b010,
      CCSF_EXECUTION = 3'b011,
      CCSF_COMPLETION = 3'b100
   } ccsf_state_t;
endpackage

// ===== tb/ccsf_assertions.sv
`timescale 1ns/1ps
module ccsf_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic engine_begin,
   input wire logic engine_abort,
   input wire logic buffer_discard,
   input wire logic timeout_error
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // write taken in first access cycle
   wire logic wr = psel && penable && pwrite && !pready;
   wire logic ln = wr && paddr == 12'h004 && pwdata == 32'h1;
   wire logic ab = wr && paddr == 12'h000 && pwdata == 32'h1;
   chk_ready_delay: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata outside answer");
   chk_begin_cause: assert property (engine_begin |->
      $past(ln, 1) || $past(ln, 2) || $past(ln, 3))
      else $error("engine_begin without launch");
   chk_begin_pulse: assert property (engine_begin |=> !engine_begin)
      else $error("engine_begin too long");
   chk_abort_cause: assert property ($rose(engine_abort) |->
      $past(ab, 1) || $past(ab, 2) || $past(ab, 3))
      else $error("engine_abort without write");
   chk_discard_pulse: assert property (buffer_discard |=> !buffer_discard)
      else $error("buffer_discard too long");
   chk_error_sticky: assert property (timeout_error |=> timeout_error)
      else $error("timeout_error dropped");
endmodule // ccsf_checker
bind ccsf_crb_ctrl ccsf_checker u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .engine_begin(engine_begin), .engine_abort(engine_abort),
   .buffer_discard(buffer_discard), .timeout_error(timeout_error));

// ===== tb/test_crb_command_cancel_start_fsm.sv
`timescale 1ns/1ps
module test_crb_command_cancel_start_fsm;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, skip = 0, loc = 0, cbw = 0, done = 0, abt = 0;
   logic eb, ea, disc, terr;
   int num_errors = 0, n_tests = 0, n_disc = 0, d0, n_begin = 0;
   // short counts keep the run brief
   ccsf_crb_ctrl #(.LONG_CYCLES(32'h32), .SHORT_CYCLES(32'h14)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .idle_skip_capability(skip),
      .locality_change(loc), .cmd_byte_written(cbw), .engine_done(done),
      .engine_aborted(abt), .engine_begin(eb), .engine_abort(ea),
      .buffer_discard(disc), .timeout_error(terr));
   initial forever #2.5 pclk = ~pclk;
   always @(posedge pclk) if (disc === 1'b1) n_disc <= n_disc + 1;
   always @(posedge pclk) if (eb === 1'b1) n_begin <= n_begin + 1;
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         num_errors++;
         report_and_stop;
      end
      @(posedge pclk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e, "register");
   endtask
   // poll because state moves a cycle after the request
   task automatic wait_fsm(input logic [31:0] e);
      for (int i = 0; i < 20; i++) begin
         apb(1'b0, ccsf_pkg::ADDR_FSM, 32'h0);
         if (rd === e) break;
      end
      check(rd, e, "fsm state");
   endtask
   task automatic hit(input int s);
      cbw <= (s == 0);
      done <= (s == 1);
      abt <= (s == 2);
      loc <= (s == 3);
      @(posedge pclk);
      {cbw, done, abt, loc} <= 4'h0;
      @(posedge pclk);
   endtask
   task automatic t_reset;
      rdchk(ccsf_pkg::ADDR_FSM, 32'h0);
      rdchk(ccsf_pkg::ADDR_STATE, 32'h2);
      rdchk(ccsf_pkg::ADDR_ABORT, 32'h0);
      apb(1'b1, ccsf_pkg::ADDR_LAUNCH, 32'h1);
      rdchk(ccsf_pkg::ADDR_LAUNCH, 32'h0);
      apb(1'b1, ccsf_pkg::ADDR_ABORT, 32'h1);
      rdchk(ccsf_pkg::ADDR_ABORT, 32'h0);
      apb(1'b1, 12'h0FC, 32'h0);
      check(err, 1'b1, "pslverr");
      $display("reset test done");
   endtask
   task automatic t_cancel;
      apb(1'b1, ccsf_pkg::ADDR_REQUEST, 32'h1);
      wait_fsm(32'h1);
      rdchk(ccsf_pkg::ADDR_STATE, 32'h0);
      rdchk(ccsf_pkg::ADDR_REQUEST, 32'h0);
      hit(0);
      wait_fsm(32'h2);
      apb(1'b1, ccsf_pkg::ADDR_LAUNCH, 32'h0);
      rdchk(ccsf_pkg::ADDR_FSM, 32'h2);
      apb(1'b1, ccsf_pkg::ADDR_LAUNCH, 32'h1);
      rdchk(ccsf_pkg::ADDR_LAUNCH, 32'h1);
      check(n_begin, 32'h1, "engine_begin");
      apb(1'b1, ccsf_pkg::ADDR_REQUEST, 32'h2);
      rdchk(ccsf_pkg::ADDR_FSM, 32'h3);
      apb(1'b1, ccsf_pkg::ADDR_ABORT, 32'h1);
      rdchk(ccsf_pkg::ADDR_ABORT, 32'h1);
      check(ea, 1'b1, "engine_abort");
      hit(2);
      wait_fsm(32'h4);
      rdchk(ccsf_pkg::ADDR_LAUNCH, 32'h0);
      check(terr, 1'b0, "timeout_error");
      apb(1'b1, ccsf_pkg::ADDR_ABORT, 32'h0);
      rdchk(ccsf_pkg::ADDR_ABORT, 32'h0);
      $display("cancel test done");
   endtask
   task automatic t_finish;
      apb(1'b1, ccsf_pkg::ADDR_REQUEST, 32'h1);
      rdchk(ccsf_pkg::ADDR_FSM, 32'h4);
      skip <= 1'b1;
      apb(1'b1, ccsf_pkg::ADDR_REQUEST, 32'h1);
      wait_fsm(32'h1);
      hit(0);
      wait_fsm(32'h2);
      apb(1'b1, ccsf_pkg::ADDR_LAUNCH, 32'h1);
      check(n_begin, 32'h2, "engine_begin");
      hit(1);
      wait_fsm(32'h4);
      rdchk(ccsf_pkg::ADDR_LAUNCH, 32'h0);
      d0 = n_disc;
      apb(1'b1, ccsf_pkg::ADDR_REQUEST, 32'h2);
      wait_fsm(32'h0);
      rdchk(ccsf_pkg::ADDR_STATE, 32'h2);
      check(32'(n_disc > d0), 32'h1, "discard");
      apb(1'b1, ccsf_pkg::ADDR_REQUEST, 32'h1);
      wait_fsm(32'h1);
      hit(3);
      wait_fsm(32'h0);
      $display("finish test done");
   endtask
   // abort left pending in execution must trip the long limit
   task automatic t_timeout;
      apb(1'b1, ccsf_pkg::ADDR_REQUEST, 32'h1);
      wait_fsm(32'h1);
      hit(0);
      wait_fsm(32'h2);
      apb(1'b1, ccsf_pkg::ADDR_LAUNCH, 32'h1);
      apb(1'b1, ccsf_pkg::ADDR_ABORT, 32'h1);
      repeat (60) @(posedge pclk);
      check(terr, 1'b1, "timeout_error");
      rdchk(ccsf_pkg::ADDR_STATE, 32'h1);
      check(ea, 1'b1, "engine_abort");
      hit(3);
      wait_fsm(32'h0);
      check(ea, 1'b0, "engine_abort");
      rdchk(ccsf_pkg::ADDR_STATE, 32'h3);
      rdchk(ccsf_pkg::ADDR_LAUNCH, 32'h0);
      apb(1'b1, ccsf_pkg::ADDR_ABORT, 32'h0);
      rdchk(ccsf_pkg::ADDR_ABORT, 32'h0);
      $display("timeout test done");
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_cancel;
      t_finish;
      t_timeout;
      report_and_stop;
   end
   initial begin
      #100000;
      num_errors++;
      report_and_stop;
   end
endmodule // test_crb_command_cancel_start_fsm
